// file: pkg/nco_pkg.sv
// Shared constants for the phase accumulator oscillator block.
package nco_pkg;
	// ==========================================================
	// Register word indices (byte address is four times these).
	localparam logic [3:0] IDX_ACC_LOW  = 4'h0;
	localparam logic [3:0] IDX_ACC_HIGH = 4'h1;
	localparam logic [3:0] IDX_ACC_UP   = 4'h2;
	localparam logic [3:0] IDX_INC_LOW  = 4'h3;
	localparam logic [3:0] IDX_INC_HIGH = 4'h4;
	localparam logic [3:0] IDX_INC_UP   = 4'h5;
	localparam logic [3:0] IDX_CTRL     = 4'h6;
	localparam logic [3:0] IDX_CLKCFG   = 4'h7;
	localparam logic [3:0] IDX_IRQ_STAT = 4'h8;
	localparam logic [3:0] IDX_IRQ_EN   = 4'h9;
	localparam logic [3:0] IDX_IRQ_CLR  = 4'hA;
	// ==========================================================
	// Field positions.
	localparam int CTRL_EN_BIT  = 7;
	localparam int CTRL_OUT_BIT = 5;
	localparam int CTRL_POL_BIT = 4;
	localparam int CTRL_PFM_BIT = 0;
	localparam int PWS_LSB      = 5;
	localparam int PWS_W        = 3;
	localparam int CKS_LSB      = 0;
	localparam int CKS_W        = 4;
	localparam int UPPER_W      = 4;
	localparam int STAT_OVF_BIT = 0;
	// ==========================================================
	// Reset values.
	localparam logic [7:0] ACC_RST     = 8'h00;
	localparam logic [7:0] INC_LOW_RST = 8'h01;
	localparam logic [7:0] INC_RST     = 8'h00;
	localparam logic [7:0] CTRL_RST    = 8'h00;
	localparam logic [7:0] CLKCFG_RST  = 8'h00;
	localparam logic [7:0] PWS_RST     = 8'h00;
	// ==========================================================
	// Source clock selection codes.
	localparam logic [3:0] CKS_SYSCLK   = 4'h0;
	localparam logic [3:0] CKS_RSVD_MID = 4'h5;
	localparam logic [3:0] CKS_LAST     = 4'hA;
	localparam int         SRC_INPUTS   = 10;
	// ==========================================================
	// Bus answer states.
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} bus_state_t;
endpackage

// file: core/nco_core.sv
// Phase accumulator oscillator with double-buffered step, Avalon-MM slave.
`timescale 1ns/1ps
module nco_core #(
	parameter int ACC_W  = 20,
	parameter int SRC_N  = nco_pkg::SRC_INPUTS
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic [3:0]        address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	input  wire logic [SRC_N-1:0]  src_clocks,
	output logic                   synth_out,
	output logic                   irq
);

	// ==========================================================
	// Parameter check.
	// The byte split and upper-nibble layout only fit a 20-bit phase.
	if (ACC_W != 20 || SRC_N != nco_pkg::SRC_INPUTS) begin : g_chk
		$error("nco_core: unsupported parameter values");
	end

	// ==========================================================
	// Bus slave.
	nco_pkg::bus_state_t bus_q, bus_d;
	logic [31:0]         rdata_q, rdata_d;
	logic                req;
	logic                wr_go;
	logic                be0;

	logic [ACC_W-1:0]    acc_q, acc_d;
	logic [7:0]          inc_l_q, inc_l_d;
	logic [7:0]          inc_h_q, inc_h_d;
	logic [3:0]          inc_u_q, inc_u_d;
	logic [ACC_W-1:0]    buf_q, buf_d;
	logic                pend_q, pend_d;
	logic [7:0]          ctrl_q, ctrl_d;
	logic [7:0]          ccfg_q, ccfg_d;
	logic                stat_q, stat_d;
	logic                ien_q, ien_d;
	logic                irq_q, irq_d;
	logic                out_q, out_d;
	logic                pin_q, pin_d;
	logic                lvl_q, lvl_d;
	logic [7:0]          pw_q, pw_d;

	assign req   = read | write;
	assign be0   = byteenable[0];
	assign wr_go = write && bus_q == nco_pkg::BUS_ACK && be0;

	always_comb begin
		bus_d   = bus_q;
		rdata_d = rdata_q;
		unique case (bus_q)
			nco_pkg::BUS_IDLE: begin
				if (req) begin
					bus_d   = nco_pkg::BUS_ACK;
					rdata_d = 32'h0000_0000;
					if (read) begin
						unique case (address)
							nco_pkg::IDX_ACC_LOW:
								rdata_d[7:0] = acc_q[7:0];
							nco_pkg::IDX_ACC_HIGH:
								rdata_d[7:0] = acc_q[15:8];
							nco_pkg::IDX_ACC_UP:
								rdata_d[3:0] = acc_q[19:16];
							nco_pkg::IDX_INC_LOW:
								rdata_d[7:0] = inc_l_q;
							nco_pkg::IDX_INC_HIGH:
								rdata_d[7:0] = inc_h_q;
							nco_pkg::IDX_INC_UP:
								rdata_d[3:0] = inc_u_q;
							nco_pkg::IDX_CTRL:
								rdata_d[7:0] = ctrl_q;
							nco_pkg::IDX_CLKCFG:
								rdata_d[7:0] = ccfg_q;
							nco_pkg::IDX_IRQ_STAT:
								rdata_d[nco_pkg::STAT_OVF_BIT] = stat_q;
							nco_pkg::IDX_IRQ_EN:
								rdata_d[nco_pkg::STAT_OVF_BIT] = ien_q;
							default:
								rdata_d = 32'h0000_0000;
						endcase
					end
				end
			end
			nco_pkg::BUS_ACK: begin
				bus_d = nco_pkg::BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_q   <= nco_pkg::BUS_IDLE;
			rdata_q <= 32'h0000_0000;
		end else begin
			bus_q   <= bus_d;
			rdata_q <= rdata_d;
		end
	end

	assign readdata    = rdata_q;
	assign waitrequest = (bus_q == nco_pkg::BUS_IDLE);

	// ==========================================================
	// Source clock selection and edge detection.
	// Inputs are treated as synchronous levels; a mux change may show
	// one spurious edge, which software avoids by switching while idle.
	logic [3:0] cks;
	logic       sel_lvl;
	logic       rise;
	logic       fall;

	assign cks = ccfg_q[nco_pkg::CKS_LSB +: nco_pkg::CKS_W];

	always_comb begin
		sel_lvl = 1'b0;
		if (cks != nco_pkg::CKS_SYSCLK && cks != nco_pkg::CKS_RSVD_MID
				&& cks <= nco_pkg::CKS_LAST) begin
			sel_lvl = src_clocks[cks - 4'h1];
		end
	end

	always_comb begin
		rise = 1'b0;
		fall = 1'b0;
		if (cks == nco_pkg::CKS_SYSCLK) begin
			rise = 1'b1;
			fall = 1'b1;
		end else begin
			rise = sel_lvl & ~lvl_q;
			fall = ~sel_lvl & lvl_q;
		end
	end

	// ==========================================================
	// Accumulator, step buffer, output and interrupt.
	logic [ACC_W:0] sum;
	logic           en;
	logic           pfm;
	logic           ovf;
	logic [7:0]     pw_len;

	assign en     = ctrl_q[nco_pkg::CTRL_EN_BIT];
	assign pfm    = ctrl_q[nco_pkg::CTRL_PFM_BIT];
	assign sum    = {1'b0, acc_q} + {1'b0, buf_q};
	assign ovf    = en & rise & sum[ACC_W];
	assign pw_len = 8'h01 << ccfg_q[nco_pkg::PWS_LSB +: nco_pkg::PWS_W];

	always_comb begin
		acc_d   = acc_q;
		inc_l_d = inc_l_q;
		inc_h_d = inc_h_q;
		inc_u_d = inc_u_q;
		buf_d   = buf_q;
		pend_d  = pend_q;
		ctrl_d  = ctrl_q;
		ccfg_d  = ccfg_q;
		stat_d  = stat_q;
		ien_d   = ien_q;
		out_d   = out_q;
		pw_d    = pw_q;
		lvl_d   = sel_lvl;
		if (en && rise) begin
			acc_d = sum[ACC_W-1:0];
		end
		if (pend_q && fall) begin
			buf_d  = {inc_u_q, inc_h_q, inc_l_q};
			pend_d = 1'b0;
		end
		if (ovf) begin
			if (pfm) begin
				out_d = 1'b1;
				pw_d  = pw_len;
			end else begin
				out_d = ~out_q;
			end
		end else if (pfm && out_q && rise) begin
			if (pw_q <= 8'h01) begin
				out_d = 1'b0;
				pw_d  = 8'h00;
			end else begin
				pw_d = pw_q - 8'h01;
			end
		end
		if (!en) begin
			out_d = 1'b0;
		end
		if (wr_go) begin
			unique case (address)
				nco_pkg::IDX_ACC_LOW:
					acc_d[7:0] = writedata[7:0];
				nco_pkg::IDX_ACC_HIGH:
					acc_d[15:8] = writedata[7:0];
				nco_pkg::IDX_ACC_UP:
					acc_d[19:16] = writedata[3:0];
				nco_pkg::IDX_INC_LOW: begin
					inc_l_d = writedata[7:0];
					pend_d  = 1'b1;
				end
				nco_pkg::IDX_INC_HIGH:
					inc_h_d = writedata[7:0];
				nco_pkg::IDX_INC_UP:
					inc_u_d = writedata[3:0];
				nco_pkg::IDX_CTRL: begin
					ctrl_d = writedata[7:0];
					ctrl_d[nco_pkg::CTRL_OUT_BIT] = out_d;
					ctrl_d[6]   = 1'b0;
					ctrl_d[3:1] = 3'h0;
				end
				nco_pkg::IDX_CLKCFG: begin
					ccfg_d    = writedata[7:0];
					ccfg_d[4] = 1'b0;
				end
				nco_pkg::IDX_IRQ_EN:
					ien_d = writedata[nco_pkg::STAT_OVF_BIT];
				nco_pkg::IDX_IRQ_CLR:
					if (writedata[nco_pkg::STAT_OVF_BIT]) begin
						stat_d = 1'b0;
					end
				default: begin
				end
			endcase
		end
		if (ovf) begin
			stat_d = 1'b1;
		end
		ctrl_d[nco_pkg::CTRL_OUT_BIT] = out_d;
		pin_d = out_d ^ ctrl_d[nco_pkg::CTRL_POL_BIT];
		irq_d = stat_d & ien_d;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q   <= {ACC_W{1'b0}};
			inc_l_q <= nco_pkg::INC_LOW_RST;
			inc_h_q <= nco_pkg::INC_RST;
			inc_u_q <= nco_pkg::INC_RST[3:0];
			buf_q   <= {12'h000, nco_pkg::INC_LOW_RST};
			pend_q  <= 1'b0;
			ctrl_q  <= nco_pkg::CTRL_RST;
			ccfg_q  <= nco_pkg::CLKCFG_RST;
			stat_q  <= 1'b0;
			ien_q   <= 1'b0;
			irq_q   <= 1'b0;
			out_q   <= 1'b0;
			pin_q   <= 1'b0;
			lvl_q   <= 1'b0;
			pw_q    <= nco_pkg::PWS_RST;
		end else begin
			acc_q   <= acc_d;
			inc_l_q <= inc_l_d;
			inc_h_q <= inc_h_d;
			inc_u_q <= inc_u_d;
			buf_q   <= buf_d;
			pend_q  <= pend_d;
			ctrl_q  <= ctrl_d;
			ccfg_q  <= ccfg_d;
			stat_q  <= stat_d;
			ien_q   <= ien_d;
			irq_q   <= irq_d;
			out_q   <= out_d;
			pin_q   <= pin_d;
			lvl_q   <= lvl_d;
			pw_q    <= pw_d;
		end
	end

	assign synth_out = pin_q;
	assign irq       = irq_q;

	// ==========================================================
	// Assertions.
	property p_upper_zero;
		@(posedge clk) disable iff (!rst_n)
		(!waitrequest && read && (address == nco_pkg::IDX_ACC_UP
			|| address == nco_pkg::IDX_INC_UP)) |-> readdata[31:4] == 28'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("upper register read shows nonzero high bits");

	property p_acc_low_read;
		@(posedge clk) disable iff (!rst_n)
		(!waitrequest && read && address == nco_pkg::IDX_ACC_LOW)
			|-> readdata[7:0] == $past(acc_q[7:0]);
	endproperty
	a_acc_low_read: assert property (p_acc_low_read)
		else $error("accumulator low byte read mismatch");

	property p_acc_space;
		@(posedge clk) disable iff (!rst_n)
		(!waitrequest && read && address == nco_pkg::IDX_ACC_UP)
			|-> readdata[3:0] == $past(acc_q[19:16]);
	endproperty
	a_acc_space: assert property (p_acc_space)
		else $error("accumulator upper nibble read mismatch");

	property p_step_add;
		@(posedge clk) disable iff (!rst_n)
		(en && rise && !wr_go) |=> acc_q == $past(sum[ACC_W-1:0]);
	endproperty
	a_step_add: assert property (p_step_add)
		else $error("accumulator did not advance by the step");

	property p_acc_hold;
		@(posedge clk) disable iff (!rst_n)
		(!en && !wr_go) |=> $stable(acc_q);
	endproperty
	a_acc_hold: assert property (p_acc_hold)
		else $error("accumulator moved while disabled");

	property p_buf_load;
		@(posedge clk) disable iff (!rst_n)
		(pend_q && fall && !(wr_go && address == nco_pkg::IDX_INC_LOW))
			|=> buf_q == $past({inc_u_q, inc_h_q, inc_l_q}) && !pend_q;
	endproperty
	a_buf_load: assert property (p_buf_load)
		else $error("step buffer not loaded on falling edge");

	property p_low_arms;
		@(posedge clk) disable iff (!rst_n)
		(wr_go && address == nco_pkg::IDX_INC_LOW)
			|=> pend_q && inc_l_q == $past(writedata[7:0]);
	endproperty
	a_low_arms: assert property (p_low_arms)
		else $error("low step write did not arm the buffer load");

	property p_no_reserved;
		@(posedge clk) disable iff (!rst_n)
		(cks > nco_pkg::CKS_LAST || cks == nco_pkg::CKS_RSVD_MID)
			|-> !rise && !fall;
	endproperty
	a_no_reserved: assert property (p_no_reserved)
		else $error("reserved source code produced an edge");

	property p_fdc_toggle;
		@(posedge clk) disable iff (!rst_n)
		(en && !pfm && !wr_go) |=> out_q == ($past(out_q) ^ $past(ovf));
	endproperty
	a_fdc_toggle: assert property (p_fdc_toggle)
		else $error("toggle mode output changed without overflow");

	property p_ovf_flag;
		@(posedge clk) disable iff (!rst_n)
		ovf |=> stat_q && irq_q == ien_q;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag)
		else $error("overflow did not set the status flag");

endmodule // nco_core

// file: tb/tb_nco_accumulator_increment.sv
// Self-checking bench for the phase accumulator oscillator block.
`timescale 1ns/1ps
module tb_nco_accumulator_increment;
	// ==========================================================
	// Design ports and model state.
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [3:0]  address = 4'h0;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0]  byteenable = 4'hF;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [9:0]  src_clocks = 10'h000;
	logic        synth_out;
	logic        irq;
	logic [31:0] rd;
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          acc_m = 0;
	int          stp_m = 1;
	int          inc_m = 1;
	int          ovf_m = 0;
	int          en_m = 0;
	int          sel_m = 0;
	int          hi_m = 0;
	int          pw_m = 1;
	int          cyc = 0;

	always #12.5 clk = ~clk;

	// Counted by non-blocking update so every reader sees one settled value.
	always @(posedge clk) cyc <= cyc + 1;

	nco_core nco_core_i (
		.clk(clk), .rst_n(rst_n), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.src_clocks(src_clocks), .synth_out(synth_out), .irq(irq));

	// ==========================================================
	// Reporting.
	task automatic give_verdict();
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk_pin(string nm, logic e, logic g);
		total_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	// ==========================================================
	// Bus cycles: request held until waitrequest is sampled low.
	task automatic bus(logic wr, logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		address <= a;
		read <= !wr;
		write <= wr;
		writedata <= {24'h0, d};
		@(posedge clk);
		while (waitrequest !== 1'b0) begin
			@(posedge clk);
		end
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic chk_reg(logic [3:0] a, int e);
		bus(1'b0, a, 8'h00);
		total_checks++;
		if (rd !== e) begin
			n_mismatch++;
			$display("Error reg %0h expected %0h seen %0h", a, e, rd);
		end
	endtask

	task automatic chk_acc();
		chk_reg(4'h0, acc_m & 32'hFF);
		chk_reg(4'h1, (acc_m >> 8) & 32'hFF);
		chk_reg(4'h2, acc_m >> 16);
	endtask

	// Source edge; the wait lets the design's edge detector catch it.
	task automatic src_set(logic v);
		int ok;
		ok = (sel_m >= 1 && sel_m <= 10 && sel_m != 5);
		@(posedge clk);
		src_clocks <= {10{v}};
		if (v && en_m && ok) begin
			acc_m = acc_m + stp_m;
			if (hi_m > 0) hi_m--;
			if (acc_m >= 32'h100000) begin
				acc_m = acc_m - 32'h100000;
				ovf_m++;
				hi_m = pw_m;
			end
		end
		if (!v && ok) stp_m = inc_m;
		repeat (6) @(posedge clk);
	endtask

	// ==========================================================
	// Tests.
	initial begin
		int s;
		int st;
		int rtab[12] = '{0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0};
		int rsv[3] = '{5, 11, 15};
		int c0;
		int ov0;
		void'($urandom(32'h2CE03F2B));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 12; i++) chk_reg(i[3:0], rtab[i]);
		$display("Test reset values done");
		bus(1'b1, 4'h2, 8'hFF);
		chk_reg(4'h2, 32'h0F);
		bus(1'b1, 4'h5, 8'hFF);
		chk_reg(4'h5, 32'h0F);
		bus(1'b1, 4'hB, 8'h5A);
		chk_reg(4'hB, 0);
		// A write without its low byte lane enabled must leave the byte alone.
		byteenable <= 4'hE;
		bus(1'b1, 4'h4, 8'h3C);
		byteenable <= 4'hF;
		chk_reg(4'h4, 0);
		$display("Test unimplemented bits done");
		// The accumulator is only written while stopped.
		s = 32'hF0000 | ($urandom % 32'h10000);
		st = 32'h40000 | ($urandom % 32'h40000);
		bus(1'b1, 4'h0, s[7:0]);
		bus(1'b1, 4'h1, s[15:8]);
		bus(1'b1, 4'h2, {4'h0, s[19:16]});
		acc_m = s;
		chk_acc();
		bus(1'b1, 4'h7, 8'h01);
		sel_m = 1;
		bus(1'b1, 4'h9, 8'h01);
		bus(1'b1, 4'h5, {4'h0, st[19:16]});
		bus(1'b1, 4'h4, st[15:8]);
		bus(1'b1, 4'h3, st[7:0]);
		inc_m = st;
		bus(1'b1, 4'h6, 8'h80);
		en_m = 1;
		// The first rise still adds the old step of one.
		repeat (5) begin
			src_set(1'b1);
			src_set(1'b0);
		end
		bus(1'b1, 4'h3, st[7:0] ^ 8'hA5);
		inc_m = st ^ 32'hA5;
		repeat (5) begin
			src_set(1'b1);
			src_set(1'b0);
		end
		chk_pin("synth_out", ovf_m[0], synth_out);
		chk_pin("irq", ovf_m > 0, irq);
		chk_reg(4'h8, ovf_m > 0);
		bus(1'b1, 4'h6, 8'h00);
		en_m = 0;
		chk_acc();
		chk_pin("synth_out", 1'b0, synth_out);
		$display("Test accumulate and step buffer done");
		bus(1'b1, 4'h9, 8'h00);
		repeat (2) @(posedge clk);
		chk_pin("irq", 1'b0, irq);
		bus(1'b1, 4'h9, 8'h01);
		repeat (2) @(posedge clk);
		chk_pin("irq", 1'b1, irq);
		bus(1'b1, 4'hA, 8'h01);
		repeat (2) @(posedge clk);
		chk_pin("irq", 1'b0, irq);
		chk_reg(4'h8, 0);
		chk_reg(4'hA, 0);
		$display("Test interrupt done");
		foreach (rsv[k]) begin
			bus(1'b1, 4'h7, rsv[k][7:0]);
			sel_m = rsv[k];
			bus(1'b1, 4'h6, 8'h80);
			en_m = 1;
			repeat (3) begin
				src_set(1'b1);
				src_set(1'b0);
			end
			bus(1'b1, 4'h6, 8'h00);
			en_m = 0;
			chk_acc();
		end
		$display("Test reserved sources done");
		// System clock source: one add per clock between the two writes.
		bus(1'b1, 4'h7, 8'hE0);
		sel_m = 0;
		bus(1'b1, 4'h3, st[7:0]);
		inc_m = st;
		stp_m = inc_m;
		bus(1'b1, 4'h6, 8'h80);
		c0 = cyc;
		ov0 = ovf_m;
		repeat ($urandom % 40) @(posedge clk);
		bus(1'b1, 4'h6, 8'h00);
		for (int j = c0; j < cyc; j++) begin
			acc_m = acc_m + stp_m;
			if (acc_m >= 32'h100000) begin
				acc_m = acc_m - 32'h100000;
				ovf_m++;
			end
		end
		chk_acc();
		chk_reg(4'h8, ovf_m > ov0);
		chk_pin("irq", ovf_m > ov0, irq);
		$display("Test system clock source done");
		// Pulse mode, width code one, inverted pin.
		bus(1'b1, 4'h7, 8'h21);
		sel_m = 1;
		pw_m = 2;
		hi_m = 0;
		bus(1'b1, 4'h6, 8'h91);
		en_m = 1;
		repeat (6) begin
			src_set(1'b1);
			chk_pin("synth_out", hi_m == 0, synth_out);
			src_set(1'b0);
		end
		bus(1'b1, 4'h6, 8'h10);
		en_m = 0;
		chk_acc();
		chk_pin("synth_out", 1'b1, synth_out);
		$display("Test pulse mode and polarity done");
		// Reset in mid-run brings every register back.
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 12; i++) chk_reg(i[3:0], rtab[i]);
		chk_pin("irq", 1'b0, irq);
		chk_pin("synth_out", 1'b0, synth_out);
		$display("Test reset in mid-run done");
		give_verdict();
	end

	// A hang shows up as a missed deadline, not a silent stall.
	initial begin
		#(25 * 20000);
		n_mismatch++;
		$display("Error watchdog expired before the tests ended");
		give_verdict();
	end
endmodule // tb_nco_accumulator_increment
